/* dv/timer_output_compare_unit_tb.sv */
// Purpose: self-checking bench for the timer output compare unit
// Assumes: register port answers one cycle after a read strobe
// Notes:   match timing is judged by counting core cycles from a count reset
module timer_output_compare_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, resetn, reg_wr, reg_rd;    // clock, strobes
    logic        cpu_irq_mask, halt_mode, ext_clk_tick; // system modes
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val; // register port
    logic [1:0]  compare_output_pin, compare_output_oe; // pins
    logic        timer_irq, wait_wake, lvl;           // irq, level
    logic [1:0]  sel;                                 // clock select
    logic [15:0] d;                                   // random value
    int          err_total, n_tests, ext_div, n, p, hi, rnd, hit;
    time         t0;                                  // count reset time
    logic [7:0]  ra [7] = '{8'h27, 8'h28, 8'h29, 8'h2A, 8'h20, 8'h21, 8'h30};
    logic [7:0]  re [7] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};

    tocu_timer_compare DUT (.core_clk, .resetn, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .cpu_irq_mask, .halt_mode,
        .ext_clk_tick, .compare_output_pin, .compare_output_oe, .timer_irq,
        .wait_wake);

    // free-running 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // external tick every fifth cycle, unrelated to register traffic
    always @(posedge core_clk) begin
        ext_div <= (ext_div == 4) ? 0 : ext_div + 1;
        ext_clk_tick <= (ext_div == 4);
    end
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask : rd
    // compare and count
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // core cycles per count for each clock select
    function automatic int ticks_per(input logic [1:0] s);
        case (s)
            tocu_pkg::CLK_DIV2: return 2;
            tocu_pkg::CLK_DIV4: return 4;
            tocu_pkg::CLK_DIV8: return 8;
            default:            return 5;
        endcase
    endfunction : ticks_per
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    // cut a hang short
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        {resetn, reg_wr, reg_rd, cpu_irq_mask, halt_mode, lvl} = '0;
        {reg_addr, reg_wdata} = '0;
        {err_total, n_tests} = '0;
        rnd = $urandom(32'hC36B9983);
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        // reset values, unmapped write then read
        wr(8'h30, 8'hFF);
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            chk("reset read", {8'h00, re[i]}, {8'h00, rd_val});
        end
        $display("test reset done");
        // random compare two values read back untouched
        repeat (4) begin
            d = 16'($urandom());
            wr(tocu_pkg::ADDR_CMP2_HI, d[15:8]);
            wr(tocu_pkg::ADDR_CMP2_LO, d[7:0]);
            rd(tocu_pkg::ADDR_CMP2_HI);
            chk("cmp2 high", {8'h00, d[15:8]}, {8'h00, rd_val});
            rd(tocu_pkg::ADDR_CMP2_LO);
            chk("cmp2 low", {8'h00, d[7:0]}, {8'h00, rd_val});
        end
        // park channel two, clear its flag with a low byte read
        wr(tocu_pkg::ADDR_CMP2_HI, 8'h80);
        wr(tocu_pkg::ADDR_CMP2_LO, 8'h00);
        rd(tocu_pkg::ADDR_STATUS);
        rd(tocu_pkg::ADDR_CMP2_LO);
        $display("test readback done");
        // match moment for every clock select; compare 0004 is 8 counts
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            lvl = ~lvl;
            wr(tocu_pkg::ADDR_CTRL_TWO, 8'h80 | {4'h0, sel, 2'h0});
            wr(tocu_pkg::ADDR_CTRL_ONE, {7'h20, lvl});
            wr(tocu_pkg::ADDR_CMP1_HI, 8'h00);
            rd(tocu_pkg::ADDR_STATUS);
            wr(tocu_pkg::ADDR_CNT_LO, 8'h00);
            t0 = $time;
            wr(tocu_pkg::ADDR_CMP1_LO, 8'h04);
            rd(tocu_pkg::ADDR_STATUS);
            chk("flag cleared", 16'h0, {15'h0, rd_val[6]});
            for (int i = 0; i < 90 && compare_output_pin[0] !== lvl; i++) begin
                @(posedge core_clk);
                #1;
            end
            n = int'(($time - t0) / 10);
            p = ticks_per(sel);
            hi = p * ((sel == tocu_pkg::CLK_DIV2) ? 8 : 9);
            hit = int'(n > hi - p && n <= hi);
            chk("match edge", 16'h1, 16'(hit));
            chk("pin level", {15'h0, lvl}, {15'h0, compare_output_pin[0]});
            rd(tocu_pkg::ADDR_STATUS);
            chk("flag set", 16'h1, {15'h0, rd_val[6]});
            chk("irq", 16'h1, {15'h0, timer_irq});
            @(posedge core_clk);
            cpu_irq_mask <= 1'b1;
            @(posedge core_clk);
            #1;
            chk("irq masked", 16'h0, {15'h0, timer_irq});
            @(posedge core_clk);
            cpu_irq_mask <= 1'b0;
            #1;
            chk("irq pending", 16'h1, {15'h0, timer_irq});
            chk("wait wake", 16'h1, {15'h0, wait_wake});
        end
        $display("test match timing done");
        // halt freezes the counter and control writes
        @(posedge core_clk);
        halt_mode <= 1'b1;
        wr(tocu_pkg::ADDR_CTRL_ONE, 8'h00);
        rd(tocu_pkg::ADDR_CNT_LO);
        d[7:0] = rd_val;
        repeat (20) @(posedge core_clk);
        rd(tocu_pkg::ADDR_CNT_LO);
        chk("halt count", {8'h00, d[7:0]}, {8'h00, rd_val});
        rd(tocu_pkg::ADDR_CTRL_ONE);
        chk("halt ctrl", {8'h00, 7'h20, lvl}, {8'h00, rd_val});
        chk("halt irq", 16'h1, {15'h0, timer_irq});
        chk("halt wake", 16'h0, {15'h0, wait_wake});
        @(posedge core_clk);
        halt_mode <= 1'b0;
        $display("test halt done");
        // high byte write alone keeps the compare inhibited
        wr(tocu_pkg::ADDR_CMP1_HI, 8'h00);
        wr(tocu_pkg::ADDR_CNT_LO, 8'h00);
        wr(tocu_pkg::ADDR_CTRL_ONE, {7'h20, ~lvl});
        repeat (60) @(posedge core_clk);
        #1;
        chk("inhibited pin", 16'(lvl), 16'(compare_output_pin[0]));
        wr(tocu_pkg::ADDR_CMP1_LO, 8'h04);
        $display("test inhibit done");
        // forced level follows the level bit, no flag, no irq
        rd(tocu_pkg::ADDR_STATUS);
        rd(tocu_pkg::ADDR_CMP1_LO);
        for (int i = 0; i < 3; i++) begin
            wr(tocu_pkg::ADDR_CTRL_ONE, {7'h24, !i[0]});
            @(posedge core_clk);
            #1;
            chk("forced pin", 16'(!i[0]), 16'(compare_output_pin[0]));
        end
        rd(tocu_pkg::ADDR_STATUS);
        chk("forced flag", 16'h0, {15'h0, rd_val[6]});
        chk("forced irq", 16'h0, {15'h0, timer_irq});
        $display("test force done");
        tally_and_finish();
    end
endmodule : timer_output_compare_unit_tb

/* dv/tocu_chk.sv */
// Purpose: port-level checks for the timer output compare unit
// Assumes: one clock, asynchronous active-low reset
// Notes:   match timing is measured by the bench, not here
module tocu_chk (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // modes and outputs
    input wire logic       cpu_irq_mask,
    input wire logic       halt_mode,
    input wire logic [1:0] compare_output_pin,
    input wire logic [1:0] compare_output_oe,
    input wire logic       timer_irq,
    input wire logic       wait_wake
);
    // single domain, so clock and disable are stated once
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    wake_tracks_irq_a: assert property (
        wait_wake == (timer_irq && !halt_mode))
        else $error("wake does not follow irq");
    irq_masked_a: assert property (
        cpu_irq_mask |-> !timer_irq)
        else $error("irq raised while masked");
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    oe_from_write_a: assert property (
        reg_wr && !halt_mode && reg_addr == tocu_pkg::ADDR_CTRL_TWO
        |=> compare_output_oe == {$past(reg_wdata[6]), $past(reg_wdata[7])})
        else $error("pin enable not taken from write");
    halt_pin_a: assert property (
        $past(halt_mode) |-> $stable(compare_output_pin))
        else $error("pin moved in halt");
    pin_one_off_a: assert property (
        !compare_output_oe[0] |=> $stable(compare_output_pin[0]))
        else $error("disabled pin one moved");
    pin_two_off_a: assert property (
        !compare_output_oe[1] |=> $stable(compare_output_pin[1]))
        else $error("disabled pin two moved");
    status_rsvd_a: assert property (
        $past(reg_rd) && $past(reg_addr) == tocu_pkg::ADDR_STATUS
        |-> (reg_rdata & 8'h97) == 8'h00)
        else $error("status reserved bit set");
endmodule : tocu_chk

bind tocu_timer_compare tocu_chk u_chk (.core_clk, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_irq_mask, .halt_mode,
    .compare_output_pin, .compare_output_oe, .timer_irq, .wait_wake);

/* verilog/tocu_pkg.sv */
// Purpose: shared constants for the timer output compare unit
// Assumes: 8-bit register port, registers at their printed offsets
// Notes:   widths fixed; one count of the counter is the compare resolution
package tocu_pkg;
    // register offsets
    localparam logic [7:0] ADDR_CTRL_ONE  = 8'h20; // timer_control_one
    localparam logic [7:0] ADDR_CTRL_TWO  = 8'h21; // timer_control_two
    localparam logic [7:0] ADDR_STATUS    = 8'h22; // timer_status_register
    localparam logic [7:0] ADDR_CNT_HI    = 8'h23; // count high byte
    localparam logic [7:0] ADDR_CNT_LO    = 8'h24; // count low, clears ovf
    localparam logic [7:0] ADDR_ALT_HI    = 8'h25; // alternate count high
    localparam logic [7:0] ADDR_ALT_LO    = 8'h26; // alternate count low
    localparam logic [7:0] ADDR_CMP1_HI   = 8'h27; // compare one high byte
    localparam logic [7:0] ADDR_CMP1_LO   = 8'h28; // compare one low byte
    localparam logic [7:0] ADDR_CMP2_HI   = 8'h29; // compare two high byte
    localparam logic [7:0] ADDR_CMP2_LO   = 8'h2A; // compare two low byte

    // timer_control_one fields
    localparam int CTL1_IRQ_EN    = 6; // compare_irq_enable
    localparam int CTL1_OVF_IRQ   = 5; // overflow_irq_enable
    localparam int CTL1_FORCE2    = 4; // forced_level_strobe, channel two
    localparam int CTL1_FORCE1    = 3; // forced_level_strobe, channel one
    localparam int CTL1_LEVEL2    = 2; // channel_output_level, two
    localparam int CTL1_LEVEL1    = 0; // channel_output_level, one
    localparam logic [7:0] CTL1_MASK = 8'h7D; // writable bits

    // timer_control_two fields
    localparam int CTL2_PIN_EN1   = 7; // channel_one_pin_enable
    localparam int CTL2_PIN_EN2   = 6; // channel_two_pin_enable
    localparam int CTL2_CLK_HI    = 3; // timer_clock_select msb
    localparam int CTL2_CLK_LO    = 2; // timer_clock_select lsb
    localparam logic [7:0] CTL2_MASK = 8'hCC; // writable bits

    // timer_status_register fields
    localparam int STAT_FLAG1     = 6; // match_flag_one
    localparam int STAT_OVF       = 5; // overflow_flag
    localparam int STAT_FLAG2     = 3; // match_flag_two

    // timer_clock_select encodings
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT  = 2'h3; // reserved code, external tick

    // prescaler terminal counts (divide minus one)
    localparam logic [2:0] PRE_DIV2_LAST = 3'h1;
    localparam logic [2:0] PRE_DIV4_LAST = 3'h3;
    localparam logic [2:0] PRE_DIV8_LAST = 3'h7;

    // reset values and fixed constants
    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [15:0] CNT_RESET = 16'hFFFC;
    localparam logic [15:0] CNT_LAST  = 16'hFFFF;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam int          NUM_CH    = 2;
endpackage : tocu_pkg

/* verilog/tocu_timer_compare.sv */
// Purpose: two-channel output compare on a 16-bit free-running counter
// Assumes: one clock core_clk, inputs synchronous, async active-low reset
// Notes:   overflow flag kept only because it shares the timer interrupt
module tocu_timer_compare (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // system modes
    input  wire logic        cpu_irq_mask,
    input  wire logic        halt_mode,
    input  wire logic        ext_clk_tick,
    // compare output pins
    output logic      [1:0]  compare_output_pin,
    output logic      [1:0]  compare_output_oe,
    // interrupt and wake
    output logic             timer_irq,
    output logic             wait_wake
);

    // register map at a glance, all byte wide:
    //   control one  - irq enables, force bits, output levels
    //   control two  - pin enables, timer clock select
    //   status       - two match flags and the overflow flag
    //   count hi/lo  - live counter, low write restarts it
    //   alt hi/lo    - same counter, never clears overflow
    //   compare hi/lo per channel - software-owned values
    // reads answer one cycle after the strobe and then fall
    // back to zero, so an idle bus always reads as zero
    //
    // timing at a glance:
    //   the prescaler counts core cycles and emits one tick
    //   per timer clock; every register still updates on
    //   each core edge, the tick only qualifies the count
    //   and the compare events
    //   divide by two fires as the count lands on the value,
    //   slower clocks one count later; both keep one timer
    //   clock of resolution

    // address decode helpers, shared by the per-channel
    // logic so both channels decode the same way
    // does this address hit the low byte of channel ch
    function automatic logic is_low_addr(input logic [7:0] a, input int ch);
        is_low_addr = (ch == 0) ? (a == tocu_pkg::ADDR_CMP1_LO)
                                : (a == tocu_pkg::ADDR_CMP2_LO);
    endfunction : is_low_addr

    // does this address hit the high byte of channel ch
    function automatic logic is_high_addr(input logic [7:0] a, input int ch);
        is_high_addr = (ch == 0) ? (a == tocu_pkg::ADDR_CMP1_HI)
                                 : (a == tocu_pkg::ADDR_CMP2_HI);
    endfunction : is_high_addr

    // per-channel one-bit state lives in two-bit vectors, bit 0 for
    // channel one and bit 1 for channel two, matching the
    // pin port order
    // software-visible and internal state
    logic [7:0]  ctrl_one_r;          // timer_control_one
    logic [7:0]  ctrl_two_r;          // timer_control_two
    logic [15:0] count_r;             // free_running_count
    logic [2:0]  presc_r;             // prescaler phase
    logic        ovf_flag_r;          // overflow_flag
    logic        ovf_seen_r;          // status read seen with ovf set
    logic [15:0] cmp_r    [2];        // channel_compare_value
    logic [1:0]  flag_r;              // channel_match_flag
    logic [1:0]  seen_r;              // status-read-seen marker
    logic [1:0]  inhibit_r;           // compare held off mid-update
    logic [1:0]  pin_r;               // pin output latch
    logic [7:0]  rdata_r;             // read data, one cycle late

    // decoded controls
    logic [1:0]  clk_sel;             // timer_clock_select
    logic        run;                 // counter may advance this cycle
    logic        tick;                // one timer clock elapsed
    logic [2:0]  presc_last;          // terminal phase for divider
    logic [15:0] count_inc;           // counter plus one
    logic [1:0]  pin_en;              // channel_pin_enable per channel
    logic [1:0]  level;               // channel_output_level per channel
    logic [1:0]  force_lvl;           // forced_level_strobe per channel
    logic [1:0]  match;               // match event this cycle
    logic        stat_rd;             // status register read
    logic        cnt_lo_acc;          // count low byte access

    // field pick-outs from the control registers, then the
    // count and access decodes; each is a plain wire so the rest of the logic reads by meaning
    assign clk_sel    = {ctrl_two_r[tocu_pkg::CTL2_CLK_HI],
                         ctrl_two_r[tocu_pkg::CTL2_CLK_LO]};
    assign pin_en     = {ctrl_two_r[tocu_pkg::CTL2_PIN_EN2],
                         ctrl_two_r[tocu_pkg::CTL2_PIN_EN1]};
    assign level      = {ctrl_one_r[tocu_pkg::CTL1_LEVEL2],
                         ctrl_one_r[tocu_pkg::CTL1_LEVEL1]};
    assign force_lvl  = {ctrl_one_r[tocu_pkg::CTL1_FORCE2],
                         ctrl_one_r[tocu_pkg::CTL1_FORCE1]};
    assign count_inc  = count_r + tocu_pkg::CNT_ONE;
    assign stat_rd    = reg_rd && (reg_addr == tocu_pkg::ADDR_STATUS);
    assign cnt_lo_acc = (reg_rd || reg_wr) &&
                        (reg_addr == tocu_pkg::ADDR_CNT_LO);

    // halt stops the whole timer; wait leaves it running
    assign run = !halt_mode;

    // divider terminal count from clock select
    always_comb begin
        unique case (clk_sel)
            tocu_pkg::CLK_DIV2: presc_last = tocu_pkg::PRE_DIV2_LAST;
            tocu_pkg::CLK_DIV4: presc_last = tocu_pkg::PRE_DIV4_LAST;
            tocu_pkg::CLK_DIV8: presc_last = tocu_pkg::PRE_DIV8_LAST;
            tocu_pkg::CLK_EXT:  presc_last = tocu_pkg::PRE_DIV2_LAST;
        endcase
    end

    // trade-off: the external tick is taken as a one-cycle
    // pulse already aligned to core_clk; synchronising and
    // edge-detecting a raw pin is left to the pad logic
    // the divider keeps running in external mode but its
    // output is ignored there
    // external mode counts on the incoming tick, otherwise the divider
    assign tick = run && ((clk_sel == tocu_pkg::CLK_EXT) ? ext_clk_tick
                          : (presc_r == presc_last));

    // prescaler phase; restarts when the counter is rewritten
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            presc_r <= 3'h0;
        end else if (cnt_lo_acc && reg_wr) begin
            // a count restart also realigns the divider phase
            presc_r <= 3'h0;
        end else if (run) begin
            // a select change mid-phase may stretch one count; harmless
            presc_r <= (presc_r >= presc_last) ? 3'h0
                                               : presc_r + 3'h1;
        end
    end

    // the counter has a single restart value, used both by
    // reset and by a write to the count low byte; halt
    // simply withholds ticks, so counting resumes in place
    // free-running counter, one count per timer clock
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= tocu_pkg::CNT_RESET;
        end else if (cnt_lo_acc && reg_wr) begin
            // restart from a count low byte write
            count_r <= tocu_pkg::CNT_RESET;
        end else if (tick) begin
            count_r <= count_inc;
        end
    end

    // overflow is kept only because it shares the one
    // timer request with the compare flags; its clear
    // mirrors the compare flags, via the count low byte
    // overflow flag: set on rollover, two-step clear, set wins
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ovf_flag_r <= 1'b0;
            ovf_seen_r <= 1'b0;
        end else begin
            if (tick && count_r == tocu_pkg::CNT_LAST) begin
                ovf_flag_r <= 1'b1;
            end else if (cnt_lo_acc && ovf_seen_r) begin
                ovf_flag_r <= 1'b0;
            end
            if (cnt_lo_acc) begin
                ovf_seen_r <= 1'b0;
            end else if (stat_rd && ovf_flag_r) begin
                ovf_seen_r <= 1'b1;
            end
        end
    end

    // halt blocks control writes so the frozen timer cannot
    // be reconfigured behind its own back
    // control registers; reserved bits stay zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_one_r <= tocu_pkg::BYTE_ZERO;
            ctrl_two_r <= tocu_pkg::BYTE_ZERO;
        end else if (reg_wr && !halt_mode) begin
            if (reg_addr == tocu_pkg::ADDR_CTRL_ONE) begin
                ctrl_one_r <= reg_wdata & tocu_pkg::CTL1_MASK;
            end
            if (reg_addr == tocu_pkg::ADDR_CTRL_TWO) begin
                ctrl_two_r <= reg_wdata & tocu_pkg::CTL2_MASK;
            end
        end
    end

    // flag clearing is a two-step handshake per channel:
    //   step one - a status read while the flag is high
    //              leaves a marker behind
    //   step two - any read or write of that channel's
    //              low compare byte consumes the marker
    //              and drops the flag
    // a low access with no marker leaves the flag alone,
    // so a stray readback cannot lose an event
    // a high byte write parks the channel until the low
    // byte follows; this keeps a half-written value from
    // firing a spurious match mid-update
    // the pin latch only moves while its pin is enabled,
    // yet flag and irq run whatever the pin enable says
    // per-channel compare logic
    for (genvar ch = 0; ch < tocu_pkg::NUM_CH; ch++) begin : g_ch
        logic lo_acc;                 // low byte read or write
        logic lo_wr;                  // low byte write
        logic hi_wr;                  // high byte write

        assign lo_acc = (reg_rd || reg_wr) && is_low_addr(reg_addr, ch);
        assign lo_wr  = reg_wr && is_low_addr(reg_addr, ch);
        assign hi_wr  = reg_wr && is_high_addr(reg_addr, ch);

        // the compare looks at the counter only on a tick, so
        // a value that the counter sits on between ticks is
        // seen once, not on every core cycle
        // divide by two: hit as the counter steps onto the value;
        // slower clocks: hit as it steps past it onto value plus one
        assign match[ch] = tick && !inhibit_r[ch] &&
            ((clk_sel == tocu_pkg::CLK_DIV2)
                ? (count_inc == cmp_r[ch])
                : (count_r == cmp_r[ch]));

        // high and low writes never coincide, so the order of
        // the two branches is only a tie-break
        // compare value: only software ever writes it
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                cmp_r[ch] <= tocu_pkg::CMP_RESET;
            end else if (hi_wr) begin
                cmp_r[ch][15:8] <= reg_wdata;
            end else if (lo_wr) begin
                cmp_r[ch][7:0] <= reg_wdata;
            end
        end

        // reset leaves the channel live, with the compare at
        // its reset value
        // inhibit between high and low byte writes
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                inhibit_r[ch] <= 1'b0;
            end else if (hi_wr) begin
                inhibit_r[ch] <= 1'b1;
            end else if (lo_wr) begin
                inhibit_r[ch] <= 1'b0;
            end
        end

        // set wins over clear so an event that lands on the
        // clearing access is never lost
        // match flag; a new match beats a clear in the same cycle
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                flag_r[ch] <= 1'b0;
            end else if (match[ch]) begin
                flag_r[ch] <= 1'b1;
            end else if (lo_acc && seen_r[ch]) begin
                flag_r[ch] <= 1'b0;
            end
        end

        // the marker is per channel, so reading status while
        // only one flag is up never arms the other channel
        // status-read marker, consumed by any low byte access
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                seen_r[ch] <= 1'b0;
            end else if (lo_acc) begin
                seen_r[ch] <= 1'b0;
            end else if (stat_rd && flag_r[ch]) begin
                seen_r[ch] <= 1'b1;
            end
        end

        // force has priority over a match in the same cycle;
        // both write the same level bit, so the order never
        // changes the level that the latch takes
        // pin latch: low in reset, takes level on match or force
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                pin_r[ch] <= 1'b0;
            end else if (pin_en[ch] && !halt_mode) begin
                // forcing never touches the flag, so it raises no irq
                if (force_lvl[ch]) begin
                    pin_r[ch] <= level[ch];
                end else if (match[ch]) begin
                    pin_r[ch] <= level[ch];
                end
            end
        end

        // disabled pin is left to general I/O; compare keeps running
        assign compare_output_oe[ch]  = pin_en[ch];
        assign compare_output_pin[ch] = pin_r[ch];
    end

    // limitation: counter bytes are read live, with no
    // latching of the low byte, so software reading the
    // count across a low byte carry may see a torn value
    // reserved status bits are built from zero so they
    // can never read back as ones
    // read data, registered one cycle after the strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= tocu_pkg::BYTE_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                tocu_pkg::ADDR_CTRL_ONE: rdata_r <= ctrl_one_r;
                tocu_pkg::ADDR_CTRL_TWO: rdata_r <= ctrl_two_r;
                tocu_pkg::ADDR_STATUS: begin
                    rdata_r <= tocu_pkg::BYTE_ZERO;
                    rdata_r[tocu_pkg::STAT_FLAG1] <= flag_r[0];
                    rdata_r[tocu_pkg::STAT_OVF]   <= ovf_flag_r;
                    rdata_r[tocu_pkg::STAT_FLAG2] <= flag_r[1];
                end
                tocu_pkg::ADDR_CNT_HI,
                tocu_pkg::ADDR_ALT_HI:  rdata_r <= count_r[15:8];
                tocu_pkg::ADDR_CNT_LO,
                tocu_pkg::ADDR_ALT_LO:  rdata_r <= count_r[7:0];
                tocu_pkg::ADDR_CMP1_HI: rdata_r <= cmp_r[0][15:8];
                tocu_pkg::ADDR_CMP1_LO: rdata_r <= cmp_r[0][7:0];
                tocu_pkg::ADDR_CMP2_HI: rdata_r <= cmp_r[1][15:8];
                tocu_pkg::ADDR_CMP2_LO: rdata_r <= cmp_r[1][7:0];
                default:                rdata_r <= tocu_pkg::BYTE_ZERO;
            endcase
        end else begin
            rdata_r <= tocu_pkg::BYTE_ZERO;
        end
    end

    assign reg_rdata = rdata_r;

    // the request is a pure function of flags and enables,
    // so clearing a flag drops it in the same cycle and a
    // masked event simply waits in its flag; nothing here
    // latches the request itself
    // one shared request for both compares and overflow, cpu-maskable;
    // stays pending in the flags while masked
    assign timer_irq = !cpu_irq_mask &&
        ((ctrl_one_r[tocu_pkg::CTL1_IRQ_EN] && (|flag_r)) ||
         (ctrl_one_r[tocu_pkg::CTL1_OVF_IRQ] && ovf_flag_r));

    // halt wake-up comes from other sources; a timer event
    // seen in halt stays pending until the device is awake
    // wakes from wait only; halt has no wake path from this block
    assign wait_wake = timer_irq && !halt_mode;

endmodule : tocu_timer_compare
